// ### common/eau_defines.vh
// Constants for the effective address unit
// Function
// - The low eleven bits of a memory-reference word are three mode bits and an 8-bit two's complement displacement that is sign-extended before the add.
// - Post-index flag is bit 10, indirect flag bit 9, pre-index flag bit 8, displacement bits 7 to 0.
// - With all mode bits clear the address is the program counter plus the displacement.
// - With the indirect flag set the word read at the intermediate address becomes a full 16-bit pointer.
// - With the pre-index flag set the base register replaces the program counter, before any indirect read.
// - With the post-index flag set the index register is added after any indirect read, or to the direct sum.
// - The displacement spans -128 to +127 words about the base.
// - Relative, pre-indexed, post-indexed or doubly indexed forms add no time of their own.
// - Each indirect step costs exactly one extra memory cycle.
// - Uncached indirect addressing adds 0.45 us over the cached figure.
// - Each local memory read adds 0.45 us, a local write adds nothing.
// - Multiport memory over short cable adds 0.85 us per read and 0.35 us per write.
// - Sequencing steps at one microinstruction each 65 ns.
// - Conditional jumps, byte and register-block instructions do not use this scheme; the unit still computes them and only flags opcodes in EXCL_MASK.
`ifndef EAU_DEFINES_VH
`define EAU_DEFINES_VH
`define EAU_XBIT        10
`define EAU_IBIT        9
`define EAU_BBIT        8
`define EAU_DISP_MSB    7
`define EAU_OP_MSB      15
`define EAU_OP_LSB      11
`define EAU_CLK_NS      20
`define EAU_UCYC_NS     65
`define EAU_LOC_RD_NS   450
`define EAU_LOC_WR_NS   0
`define EAU_MP_RD_NS    850
`define EAU_MP_WR_NS    350
`define EAU_IND_NS      450
`define EAU_MEM_CACHE   2'h0
`define EAU_MEM_LOCAL   2'h1
`define EAU_MEM_MPORT   2'h2
`endif

// ### rtl/eau_effective_address.v
// Effective address unit for memory-reference instructions
`include "eau_defines.vh"
module eau_effective_address #(
  parameter EXCL_MASK = 32'h0000_0000
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Instruction request
  input  wire        req_valid,
  input  wire [15:0] instr,
  input  wire [15:0] pc_value,
  input  wire [15:0] area_anchor,
  input  wire [15:0] second_offset_word,
  input  wire [1:0]  mem_kind,
  input  wire        is_write,
  // Pointer read port
  output wire        rd_req,
  output wire [15:0] rd_addr,
  input  wire        rd_valid,
  input  wire [15:0] rd_data,
  // Result
  output wire        ea_valid,
  output wire [15:0] ea_addr,
  output wire [4:0]  ea_opcode,
  output wire        ea_excluded,
  output wire [7:0]  ea_extra_cycles,
  output wire        busy
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WAIT = 2'h1;
  localparam [1:0] S_UTCK = 2'h2;

  // Nanoseconds to clock cycles, rounded up: an added time is a least time
  function [7:0] ns_to_cyc;
    input integer ns;
    integer       cyc;
    begin
      cyc       = (ns + `EAU_CLK_NS - 1) / `EAU_CLK_NS;
      ns_to_cyc = cyc[7:0];
    end
  endfunction

  localparam [7:0] UCYC   = ns_to_cyc(`EAU_UCYC_NS);
  localparam [7:0] C_IND  = ns_to_cyc(`EAU_IND_NS);
  localparam [7:0] C_LRD  = ns_to_cyc(`EAU_LOC_RD_NS);
  localparam [7:0] C_LWR  = ns_to_cyc(`EAU_LOC_WR_NS);
  localparam [7:0] C_MRD  = ns_to_cyc(`EAU_MP_RD_NS);
  localparam [7:0] C_MWR  = ns_to_cyc(`EAU_MP_WR_NS);

  // Sign-extended wrapping add
  function [15:0] add_disp;
    input [15:0] base;
    input [7:0]  d;
    begin
      add_disp = base + {{8{d[`EAU_DISP_MSB]}}, d};
    end
  endfunction

  // Extra cycles for one operand reference by memory type
  function [7:0] ref_cost;
    input [1:0] kind;
    input       wr;
    begin
      case (kind)
        `EAU_MEM_LOCAL: ref_cost = wr ? C_LWR : C_LRD;
        `EAU_MEM_MPORT: ref_cost = wr ? C_MWR : C_MRD;
        default:        ref_cost = 8'h00;
      endcase
    end
  endfunction

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         post_q;
  reg         post_d;
  reg  [15:0] index_q;
  reg  [15:0] index_d;
  reg  [7:0]  extra_q;
  reg  [7:0]  extra_d;
  reg  [7:0]  utick_q;
  reg  [7:0]  utick_d;
  reg         rd_req_q;
  reg         rd_req_d;
  reg  [15:0] rd_addr_q;
  reg  [15:0] rd_addr_d;
  reg         ea_valid_q;
  reg         ea_valid_d;
  reg  [15:0] ea_addr_q;
  reg  [15:0] ea_addr_d;
  reg  [4:0]  ea_opcode_q;
  reg  [4:0]  ea_opcode_d;
  reg         ea_excluded_q;
  reg         ea_excluded_d;
  reg  [7:0]  ea_cycles_q;
  reg  [7:0]  ea_cycles_d;
  reg         busy_q;
  reg         busy_d;

  wire        f_post  = instr[`EAU_XBIT];
  wire        f_ind   = instr[`EAU_IBIT];
  wire        f_pre   = instr[`EAU_BBIT];
  wire [7:0]  disp    = instr[`EAU_DISP_MSB:0];
  wire [4:0]  opc     = instr[`EAU_OP_MSB:`EAU_OP_LSB];
  // Pre-index picks the base before any indirect step
  wire [15:0] inter   = add_disp(f_pre ? area_anchor : pc_value, disp);
  // Excluded opcodes carry their own formats; flagged, still computed
  wire        excl    = EXCL_MASK[opc];
  wire [7:0]  base_x  = ref_cost(mem_kind, is_write);
  wire [15:0] dir_sum = f_post ? inter + second_offset_word : inter;

  always @* begin
    state_d       = state_q;
    post_d        = post_q;
    index_d       = index_q;
    extra_d       = extra_q;
    utick_d       = utick_q;
    rd_req_d      = 1'b0;
    rd_addr_d     = rd_addr_q;
    ea_valid_d    = 1'b0;
    ea_addr_d     = ea_addr_q;
    ea_opcode_d   = ea_opcode_q;
    ea_excluded_d = ea_excluded_q;
    ea_cycles_d   = ea_cycles_q;
    busy_d        = busy_q;
    case (state_q)
      S_IDLE: begin
        if (req_valid) begin
          ea_opcode_d   = opc;
          ea_excluded_d = excl;
          post_d        = f_post;
          index_d       = second_offset_word;
          if (f_ind) begin
            // One memory cycle for the pointer read
            rd_req_d  = 1'b1;
            rd_addr_d = inter;
            busy_d    = 1'b1;
            state_d   = S_WAIT;
            if (mem_kind == `EAU_MEM_CACHE) begin
              extra_d = base_x;
            end else begin
              extra_d = base_x + C_IND;
            end
          end else begin
            // Indexing alone adds no time
            ea_addr_d   = dir_sum;
            ea_cycles_d = base_x;
            ea_valid_d  = 1'b1;
          end
        end
      end
      S_WAIT: begin
        // Answers outside this state are ignored
        if (rd_valid) begin
          // Fetched word is a full pointer, post-index after it
          ea_addr_d = post_q ? rd_data + index_q : rd_data;
          utick_d   = UCYC;
          state_d   = S_UTCK;
        end
      end
      S_UTCK: begin
        // Hold result for one microinstruction step
        if (utick_q <= 8'h01) begin
          ea_cycles_d = extra_q;
          ea_valid_d  = 1'b1;
          busy_d      = 1'b0;
          state_d     = S_IDLE;
        end else begin
          utick_d = utick_q - 8'h01;
        end
      end
      default: begin
        state_d = S_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= S_IDLE;
      post_q        <= 1'b0;
      index_q       <= 16'h0000;
      extra_q       <= 8'h00;
      utick_q       <= 8'h00;
      rd_req_q      <= 1'b0;
      rd_addr_q     <= 16'h0000;
      ea_valid_q    <= 1'b0;
      ea_addr_q     <= 16'h0000;
      ea_opcode_q   <= 5'h00;
      ea_excluded_q <= 1'b0;
      ea_cycles_q   <= 8'h00;
      busy_q        <= 1'b0;
    end else begin
      state_q       <= state_d;
      post_q        <= post_d;
      index_q       <= index_d;
      extra_q       <= extra_d;
      utick_q       <= utick_d;
      rd_req_q      <= rd_req_d;
      rd_addr_q     <= rd_addr_d;
      ea_valid_q    <= ea_valid_d;
      ea_addr_q     <= ea_addr_d;
      ea_opcode_q   <= ea_opcode_d;
      ea_excluded_q <= ea_excluded_d;
      ea_cycles_q   <= ea_cycles_d;
      busy_q        <= busy_d;
    end
  end

  // Outputs come straight from their flops
  assign rd_req          = rd_req_q;
  assign rd_addr         = rd_addr_q;
  assign ea_valid        = ea_valid_q;
  assign ea_addr         = ea_addr_q;
  assign ea_opcode       = ea_opcode_q;
  assign ea_excluded     = ea_excluded_q;
  assign ea_extra_cycles = ea_cycles_q;
  assign busy            = busy_q;
endmodule // eau_effective_address

// ### dv/eau_memory_model.sv
// Pointer memory answering the unit's read port
module eau_memory_model (
  input  wire logic        sys_clk,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output logic             rd_valid = 1'b0,
  output logic      [15:0] rd_data = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  bit slow = 1'b0;
  // Prompt and slow answers alternate; idle data flips so no stale word passes
  always @(negedge sys_clk) begin
    rd_valid <= 1'b0;
    rd_data  <= ~rd_data;
    if (rd_req) begin
      cnt  <= slow ? 4 : 1;
      slow <= !slow;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        rd_valid <= 1'b1;
        rd_data  <= rd_addr ^ 16'hC35A;
      end
    end
  end
endmodule // eau_memory_model

// ### dv/eau_monitor.sv
// Checker for the effective address unit
module eau_monitor #(parameter EXCL_MASK = 32'h0000_0000) (
  input wire logic        sys_clk, rst_n, req_valid, is_write, rd_req, rd_valid,
  input wire logic        ea_valid, ea_excluded, busy,
  input wire logic [1:0]  mem_kind,
  input wire logic [4:0]  ea_opcode,
  input wire logic [7:0]  ea_extra_cycles,
  input wire logic [15:0] instr, pc_value, area_anchor, second_offset_word,
  input wire logic [15:0] rd_addr, rd_data, ea_addr);
  logic [15:0] psum, dsum, post_q;
  logic [7:0]  cost_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  assign psum = (instr[8] ? area_anchor : pc_value) + {{8{instr[7]}}, instr[7:0]};
  assign dsum = psum + (instr[10] ? second_offset_word : 16'h0000);
  // Post-index term held from the taken request
  always_ff @(posedge sys_clk) if (req_valid && !busy) post_q <= dsum - psum;
  // Expected added cycles of the taken request, rounded up from the listed times
  always_ff @(posedge sys_clk)
    if (req_valid && !busy)
      cost_q <= (mem_kind == 2'h1 ? (is_write ? 8'h00 : 8'h17) :
                 mem_kind == 2'h2 ? (is_write ? 8'h12 : 8'h2B) : 8'h00) +
                ((instr[9] && mem_kind != 2'h0) ? 8'h17 : 8'h00);
  sequence take_dir; req_valid && !busy && !instr[9]; endsequence
  sequence take_ind; req_valid && !busy && instr[9]; endsequence
  sequence ptr_back; busy && rd_valid; endsequence
  chk_dir_addr: assert property (take_dir |=> ea_valid && ea_addr == $past(dsum))
    else $error("direct address wrong");
  chk_ptr_read: assert property (take_ind |=> rd_req && rd_addr == $past(psum))
    else $error("pointer read wrong");
  chk_ind_addr: assert property (ptr_back |=> !ea_valid[*4] ##1
    ea_valid && ea_addr == $past(rd_data, 5) + post_q) else $error("indirect address wrong");
  chk_ind_busy: assert property (take_ind |=> busy[*3])
    else $error("busy dropped early");
  chk_op_field: assert property (take_dir |=> ea_opcode == $past(instr[15:11]))
    else $error("opcode wrong");
  chk_cache_cost: assert property ((take_dir and mem_kind == 2'h0) |=>
    ea_extra_cycles == 8'h00) else $error("cache cost wrong");
  chk_local_cost: assert property ((take_dir and mem_kind == 2'h1) |=>
    ea_extra_cycles == ($past(is_write) ? 8'h00 : 8'h17)) else $error("local cost wrong");
  chk_mport_cost: assert property ((take_dir and mem_kind == 2'h2) |=>
    ea_extra_cycles == ($past(is_write) ? 8'h12 : 8'h2B)) else $error("multiport cost wrong");
  chk_excl_flag: assert property (take_dir |=>
    ea_excluded == EXCL_MASK[$past(instr[15:11])]) else $error("excluded flag wrong");
  chk_ind_cost: assert property ($fell(busy) |-> ea_valid &&
    ea_extra_cycles == cost_q) else $error("indirect cost wrong");
endmodule // eau_monitor
bind eau_effective_address eau_monitor #(.EXCL_MASK(EXCL_MASK)) u_mon (.*);

// ### dv/eau_effective_address_tb_top.sv
// Self-checking bench for the effective address unit
module eau_effective_address_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst_n, req_valid, is_write, rd_req, rd_valid, ea_valid, busy;
  logic [1:0]  mem_kind;
  logic [4:0]  ea_opcode;
  logic        ea_excluded;
  logic [7:0]  ea_extra_cycles;
  logic [15:0] instr, pc_value, area_anchor, second_offset_word, rd_addr, rd_data, ea_addr;
  int          errors, checks, seed = 32'hC9369FA7;
  bit          hung = 1'b0;
  // Arbitrary set of opcodes flagged as using their own format
  localparam logic [31:0] EXCL = 32'h8000_0401;
  eau_effective_address #(.EXCL_MASK(EXCL)) dut (.*);
  eau_memory_model mem (.*);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  // Added cycles of one request, rounded up from the listed times
  function automatic logic [7:0] exp_cost(logic [15:0] ins);
    logic [7:0] c;
    case (mem_kind)
      2'h1: c = is_write ? 8'h00 : 8'h17;
      2'h2: c = is_write ? 8'h12 : 8'h2B;
      default: c = 8'h00;
    endcase
    if (ins[9] && mem_kind != 2'h0) c = c + 8'h17;
    return c;
  endfunction
  function automatic logic [15:0] exp_ea(logic [15:0] ins);
    logic [15:0] s;
    s = (ins[8] ? area_anchor : pc_value) + {{8{ins[7]}}, ins[7:0]};
    if (ins[9]) s = s ^ 16'hC35A;
    return s + (ins[10] ? second_offset_word : 16'h0000);
  endfunction
  // Direct requests stay raised so they run back to back
  task automatic run_op(logic [15:0] ins);
    int n;
    instr = ins;
    req_valid = 1'b1;
    {pc_value, area_anchor} = $random(seed);
    {second_offset_word, is_write} = 17'($random(seed));
    mem_kind = 2'($unsigned($random(seed)) % 3);
    @(negedge sys_clk);
    if (ea_valid !== 1'b1) req_valid = 1'b0;
    for (n = 0; ea_valid !== 1'b1 && n < 20; n++) @(negedge sys_clk);
    if (n == 20) begin
      errors++;
      hung = 1'b1;
      return;
    end
    check("ea_addr", ea_addr, exp_ea(ins));
    check("ea_opcode", 16'(ea_opcode), 16'(ins[15:11]));
    check("ea_excluded", 16'(ea_excluded), 16'(EXCL[ins[15:11]]));
    check("ea_extra_cycles", 16'(ea_extra_cycles), 16'(exp_cost(ins)));
  endtask
  initial begin
    {rst_n, req_valid, is_write, mem_kind} = '0;
    {instr, pc_value, area_anchor, second_offset_word} = '0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (!hung) run_op({5'h0A, 3'(i), i[3] ? 8'h80 : 8'h7F});
    end
    repeat (80) begin
      if (!hung) run_op(16'($random(seed)));
    end
    req_valid = 1'b0;
    report_and_stop();
  end
endmodule // eau_effective_address_tb_top
